/* File: design/pic_phy_interrupt_control.sv */
`timescale 1ns/1ps
// What this block does
// - accept link, energy, speed, duplex, negotiation, counter events
// - each status bit needs its own enable bit
// - control bits 15:4 ignore writes, read zero
// - remap one: timesync bit 11, speed-or-duplex bit 12
// - remap zero: duplex bit 11, speed bit 12
// - test bit forces interrupt until cleared
// - global gate suppresses all event interrupts
// - output enable drives pin, else power-down input
// - control bits reset to zero
// - reading status register clears pending bits
// - status bits set even when disabled
// - timesync not rearmed until its status empty
module pic_phy_interrupt_control
	import pic_pkg::*;
(
	// clock and reset
	input wire logic refClk,
	input wire logic sysRst,
	// management register access
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	// event strobes, index order per package
	input wire logic [7:0] eventPulse,
	// timesync status register has entries left
	input wire logic timesyncStatusBusy,
	// shared power-down / interrupt pin
	input wire logic powerdownOrIrqPinIn,
	output logic powerdownOrIrqPinOut,
	output logic powerdownOrIrqPinOe,
	output logic powerDownReq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] ctrl;
		logic [6:0] pend;
		logic [6:0] en;
		logic tsArmed;
		logic [15:0] rdata;
		logic pinOut;
		logic pinOe;
		logic pdReq;
	} pic_state_type;

	pic_state_type st;
	pic_state_type next_st;

	function automatic logic [15:0] statusWord(input logic [6:0] p,
			input logic [6:0] e);
		statusWord = {p, e, 2'b00};
	endfunction

	logic [6:0] raise;
	logic anyIrq;
	logic stRead;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		raise = '0;
		stRead = regRead && (regAddr == STAT_ADDR);
		raise[ST_CNT_BIT - ST_FIRST] = eventPulse[EV_CNT];
		raise[ST_ANC_BIT - ST_FIRST] = eventPulse[EV_ANC];
		raise[ST_LINK_BIT - ST_FIRST] = eventPulse[EV_LINK];
		raise[ST_ED_BIT - ST_FIRST] = eventPulse[EV_ED];
		raise[ST_LQ_BIT - ST_FIRST] = eventPulse[EV_LQ];
		if (st.ctrl[CTRL_REMAP_BIT]) begin
			// timesync held off until its status drains
			raise[ST_B11_BIT - ST_FIRST] = eventPulse[EV_TS] && st.tsArmed;
			raise[ST_B12_BIT - ST_FIRST] =
				eventPulse[EV_SPD] || eventPulse[EV_DUP];
		end else begin
			raise[ST_B11_BIT - ST_FIRST] = eventPulse[EV_DUP];
			raise[ST_B12_BIT - ST_FIRST] = eventPulse[EV_SPD];
		end
		if (raise[ST_B11_BIT - ST_FIRST] && st.ctrl[CTRL_REMAP_BIT]) begin
			next_st.tsArmed = 1'b0;
		end else if (!timesyncStatusBusy) begin
			next_st.tsArmed = 1'b1;
		end
		// set wins over clear-on-read; no enable gating here
		if (stRead) begin
			next_st.pend = raise;
		end else begin
			next_st.pend = st.pend | raise;
		end
		if (regWrite && regAddr == CTRL_ADDR) begin
			next_st.ctrl = regWdata[3:0];
		end
		if (regWrite && regAddr == STAT_ADDR) begin
			next_st.en = regWdata[8:2];
		end
		// registered read data, valid the cycle after regRead
		case (regAddr)
			CTRL_ADDR: next_st.rdata = {12'h000, st.ctrl};
			STAT_ADDR: next_st.rdata = statusWord(st.pend, st.en);
			default: next_st.rdata = 16'h0000;
		endcase
		if (!regRead) begin
			next_st.rdata = st.rdata;
		end
		// enabled pending gated globally, test bypasses gate
		anyIrq = (st.ctrl[CTRL_GATE_BIT] && |(st.pend & st.en))
			|| st.ctrl[CTRL_TEST_BIT];
		next_st.pinOe = st.ctrl[CTRL_OE_BIT];
		next_st.pinOut = !anyIrq;
		next_st.pdReq = !st.ctrl[CTRL_OE_BIT] && !powerdownOrIrqPinIn;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge refClk or posedge sysRst) begin
		if (sysRst) begin
			st.ctrl <= CTRL_RESET;
			st.pend <= PEND_RESET;
			st.en <= EN_RESET;
			st.tsArmed <= 1'b1;
			st.rdata <= 16'h0000;
			st.pinOut <= 1'b1;
			st.pinOe <= 1'b0;
			st.pdReq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;
	assign powerdownOrIrqPinOut = st.pinOut;
	assign powerdownOrIrqPinOe = st.pinOe;
	assign powerDownReq = st.pdReq;
endmodule

/* File: design/pic_pkg.sv */
package pic_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [4:0] CTRL_ADDR = 5'h11;
	localparam logic [4:0] STAT_ADDR = 5'h12;
	localparam logic [4:0] TSST_ADDR = 5'h14;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTRL_OE_BIT = 0;
	localparam int CTRL_GATE_BIT = 1;
	localparam int CTRL_TEST_BIT = 2;
	localparam int CTRL_REMAP_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// ----------------------------------------
	// status register fields (pending bits)
	// ----------------------------------------
	localparam int ST_CNT_BIT = 9;
	localparam int ST_ANC_BIT = 10;
	localparam int ST_B11_BIT = 11;
	localparam int ST_B12_BIT = 12;
	localparam int ST_LINK_BIT = 13;
	localparam int ST_ED_BIT = 14;
	localparam int ST_LQ_BIT = 15;
	localparam int ST_FIRST = 9;
	localparam int ST_COUNT = 7;
	localparam logic [6:0] PEND_RESET = 7'h00;
	localparam logic [6:0] EN_RESET = 7'h00;
	// event input index order
	localparam int EV_CNT = 0;
	localparam int EV_ANC = 1;
	localparam int EV_DUP = 2;
	localparam int EV_SPD = 3;
	localparam int EV_LINK = 4;
	localparam int EV_ED = 5;
	localparam int EV_LQ = 6;
	localparam int EV_TS = 7;
endpackage

/* File: sim/pic_checker.sv */
`timescale 1ns/1ps
module pic_checker
	import pic_pkg::*;
(
	// bus and pin
	input wire logic refClk, sysRst, regWrite, regRead,
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWdata, regRdata,
	input wire logic [7:0] eventPulse,
	input wire logic powerdownOrIrqPinOut, powerdownOrIrqPinOe
);
	logic [3:0] ctl;
	default clocking @(posedge refClk); endclocking
	default disable iff (sysRst);
	// shadow copy, so pin checks need no peek inside
	always_ff @(posedge refClk or posedge sysRst) begin
		if (sysRst) ctl <= 4'h0;
		else if (regWrite && regAddr == CTRL_ADDR) ctl <= regWdata[3:0];
	end
	sequence rd; regRead && regAddr == STAT_ADDR; endsequence
	a_upper_zero: assert property (regRead && regAddr == CTRL_ADDR
		|=> regRdata[15:4] == 12'h000) else $error("upper bits");
	a_event_pend: assert property (eventPulse[EV_LQ] ##1 !regRead
		##1 rd |=> regRdata[ST_LQ_BIT]) else $error("pend lost");
	a_read_clear: assert property (regRead && regAddr == STAT_ADDR &&
		!eventPulse ##1 !eventPulse ##1 rd |=> !regRdata[15:9])
		else $error("not cleared");
	a_dup_low: assert property (!ctl[3] && eventPulse[EV_DUP] ##1 rd
		|=> regRdata[ST_B11_BIT]) else $error("bit 11");
	a_dup_high: assert property (ctl[3] && eventPulse[EV_DUP] ##1 rd
		|=> regRdata[ST_B12_BIT]) else $error("bit 12");
	a_test_pin: assert property (ctl[2] [*2] |-> !powerdownOrIrqPinOut)
		else $error("test irq");
	a_gate_off: assert property ((!ctl[1] && !ctl[2]) [*2] |->
		powerdownOrIrqPinOut) else $error("gate");
	a_oe_off: assert property (!ctl[0] [*2] |-> !powerdownOrIrqPinOe)
		else $error("oe");
endmodule
bind pic_phy_interrupt_control pic_checker chk (.*);

/* File: sim/pic_host_model.sv */
`timescale 1ns/1ps
// host end of the shared pin; host drives hostPdN onto it when the PHY output enable is off
module pic_host_model (
	input wire logic drvOe, drvOut, hostPdN,
	output logic pinLevel, irqSeen
);
	assign pinLevel = drvOe ? drvOut : hostPdN;
	assign irqSeen = drvOe && !pinLevel;
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
	failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
	import pic_pkg::*;
	logic refClk = 0, sysRst = 1, wr = 0, rd = 0, pdN = 1, tsBusy = 0;
	logic oe, po, pdq, pin, irq;
	logic [4:0] ad = 0;
	logic [15:0] wd = 0, rdat;
	logic [7:0] ev = 0;
	int failures = 0, totalChecks = 0;
	always #2.5 refClk = ~refClk;
	pic_phy_interrupt_control dut (.refClk, .sysRst, .regWrite(wr),
		.regRead(rd), .regAddr(ad), .regWdata(wd), .regRdata(rdat),
		.eventPulse(ev), .timesyncStatusBusy(tsBusy),
		.powerdownOrIrqPinIn(pin), .powerdownOrIrqPinOut(po),
		.powerdownOrIrqPinOe(oe), .powerDownReq(pdq));
	pic_host_model host (.drvOe(oe), .drvOut(po), .hostPdN(pdN),
		.pinLevel(pin), .irqSeen(irq));
	task completeRun;
		$display("checks %0d errors %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// write d, or read and expect d
	task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		{wr, rd, ad, wd} = {w, !w, a, d};
		@(posedge refClk);
		#1 {wr, rd} = 2'b00;
		@(posedge refClk);
		#1 if (!w) `CK("reg", d, rdat)
	endtask
	task pulse(input int b);
		ev[b] = 1'b1;
		@(posedge refClk);
		#1 ev = 8'h00;
	endtask
	task waitIrq(input logic e);
		for (int i = 0; i < 20 && irq !== e; i++) #5;
		`CK("irq", e, irq)
		if (irq !== e) completeRun();
	endtask
	initial begin
		repeat (6) @(posedge refClk);
		#1 sysRst = 0;
		acc(0, CTRL_ADDR, 16'h0000);
		acc(1, CTRL_ADDR, 16'hfff3);
		acc(0, CTRL_ADDR, 16'h0003);
		$display("test regs done");
		acc(1, STAT_ADDR, 16'h0010);
		pulse(EV_DUP);
		waitIrq(1);
		acc(0, STAT_ADDR, 16'h0810);
		acc(0, STAT_ADDR, 16'h0010);
		waitIrq(0);
		acc(1, CTRL_ADDR, 16'h0001);
		pulse(EV_LQ);
		pulse(EV_DUP);
		`CK("irq", 1'b0, irq)
		acc(0, STAT_ADDR, 16'h8810);
		pulse(EV_CNT);
		pulse(EV_ANC);
		pulse(EV_LINK);
		pulse(EV_ED);
		acc(0, STAT_ADDR, 16'h6610);
		acc(1, CTRL_ADDR, 16'h0009);
		pulse(EV_DUP);
		acc(0, STAT_ADDR, 16'h1010);
		// after its first event, timesync source stays quiet until its status drains
		tsBusy = 1;
		pulse(EV_TS);
		acc(0, STAT_ADDR, 16'h0810);
		pulse(EV_TS);
		acc(0, STAT_ADDR, 16'h0010);
		tsBusy = 0;
		@(posedge refClk);
		#1 pulse(EV_TS);
		acc(0, STAT_ADDR, 16'h0810);
		$display("test events done");
		acc(1, CTRL_ADDR, 16'h0005);
		waitIrq(1);
		acc(1, CTRL_ADDR, 16'h0001);
		waitIrq(0);
		acc(1, CTRL_ADDR, 16'h0000);
		pdN = 0;
		#10 `CK("pd", 1'b1, pdq)
		$display("test pin done");
		completeRun();
	end
endmodule
